// file: inc/lbs_map.svh
// Register offsets, field positions, reset values and message constants of the burst scheduler.
// Assumes inclusion by bare name from the package and from the design files.
`ifndef LBS_MAP_SVH
`define LBS_MAP_SVH

// Register byte offsets on the APB side.
`define LBS_CTRL_OFF 8'h00
`define LBS_STATUS_OFF 8'h04
`define LBS_LON_OFF 8'h08
`define LBS_LAT_OFF 8'h0c
`define LBS_COGSOG_OFF 8'h10
`define LBS_TIME_OFF 8'h14
`define LBS_SLOT_OFF 8'h18

// Control register bit positions.
`define LBS_CTRL_ACTIVE 0
`define LBS_CTRL_TEST 1
`define LBS_CTRL_SECOND 2
`define LBS_CTRL_FIX 3

// Field positions inside packed registers.
`define LBS_SOG_LSB 16
`define LBS_SEC_LSB 16
`define LBS_STAT_STATE_LSB 4
`define LBS_STAT_FIX_BIT 6
`define LBS_STAT_INCR_LSB 16

// Reset values.
`define LBS_CTRL_RST 4'h0
`define LBS_LON_RST 28'h6791ac0
`define LBS_LAT_RST 27'h3412140
`define LBS_COG_RST 12'he10
`define LBS_SOG_RST 10'h3ff
`define LBS_SUB_RST 14'h0000
`define LBS_SEC_RST 6'h3f
`define LBS_LFSR_SEED 16'hace1

// Message contents.
`define LBS_MSG_POS 6'h01
`define LBS_MSG_SAFETY 6'h0e
`define LBS_NAV_ALERT 4'he
`define LBS_NAV_UNDEF 4'hf
`define LBS_LAST_MSG 3'h7
`define LBS_LAST_BURST 3'h7
`define LBS_TIMEOUT_TOP 3'h7
`define LBS_SAFETY_POS_A 3'h4
`define LBS_SAFETY_POS_B 3'h5

// Position field defaults and fallback codes.
`define LBS_LON_NA 28'h6791ac0
`define LBS_LAT_NA 27'h3412140
`define LBS_COG_NA 12'he10
`define LBS_SOG_NA 10'h3ff
`define LBS_TS_NA 6'h3f
`define LBS_TS_EST 6'h3e
`define LBS_SYNC_EST 2'h3
`define LBS_SYNC_UTC 2'h0

// Random slot increment window, 2025 to 2475 slots.
`define LBS_INCR_BASE 14'h07e9
`define LBS_INCR_SPAN 9'h1c3

`endif

// file: inc/lbs_pkg.sv
// Types shared by the burst scheduler: message descriptor and sequencer states.
// Assumes lbs_map.svh is on the include path.
`include "lbs_map.svh"

package lbs_pkg;

    // One transmission as handed to the radio.
    typedef struct packed {
        logic channel;
        logic [5:0] msg_type;
        logic text_test;
        logic [3:0] nav_status;
        logic [2:0] time_out;
        logic [13:0] sub_msg;
        logic [27:0] lon;
        logic [26:0] lat;
        logic [11:0] course_over_ground;
        logic [9:0] speed_over_ground;
        logic [5:0] tstamp;
        logic [1:0] sync_state;
    } lbs_desc_s;

    // Position block that travels together into a descriptor.
    typedef struct packed {
        logic [27:0] lon;
        logic [26:0] lat;
        logic [11:0] course_over_ground;
        logic [9:0] speed_over_ground;
        logic [5:0] tstamp;
        logic [1:0] sync_state;
    } lbs_pos_s;

    typedef enum logic [1:0] {
        lbs_idle,
        lbs_wait,
        lbs_send
    } lbs_state_e;

    typedef logic [2:0] lbs_idx_t;

endpackage

// file: rtl/lbs_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module lbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];

    // Storage is written only on an accepted push.
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Occupancy follows pushes and pops of the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end

endmodule
`default_nettype wire

// file: rtl/lbs_rand.sv
// Free-running pseudo-random source for the slot increment.
// Assumes one clock; the value changes every cycle.
`timescale 1ns/100ps
`default_nettype none
`include "lbs_map.svh"

module lbs_rand (
    input wire logic pclk,
    input wire logic presetn,
    output logic [15:0] rand_val
);
    logic [15:0] lfsr_reg;

    // Galois shift register with a maximal-length tap set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_reg <= `LBS_LFSR_SEED;
        end else begin
            lfsr_reg <= {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? 16'hb400 : 16'h0000);
        end
    end

    assign rand_val = lfsr_reg;

endmodule
`default_nettype wire

// file: rtl/lbs_top.sv
// Burst scheduler: chooses each transmission of a locator burst and queues it for the radio.
// Assumes an APB master on pclk and a burst_start pulse once a minute from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
`include "lbs_map.svh"

module lbs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic burst_start,
    output logic tx_valid,
    input wire logic tx_ready,
    output lbs_pkg::lbs_desc_s tx_desc
);
    import lbs_pkg::*;

    // Software-written registers.
    logic active_en_reg;
    logic start_second_reg;
    logic fix_valid_reg;
    logic [27:0] lon_reg;
    logic [26:0] lat_reg;
    logic [11:0] cog_reg;
    logic [9:0] sog_reg;
    logic [13:0] utc_reg;
    logic [5:0] sec_reg;
    logic [13:0] slot_reg;
    logic test_go;

    // Last known position held across a lost fix.
    logic [27:0] last_lon_reg;
    logic [26:0] last_lat_reg;
    logic [11:0] last_cog_reg;
    logic [9:0] last_sog_reg;
    logic had_fix_reg;

    // Sequencer state.
    lbs_state_e state_reg;
    lbs_idx_t burst_reg;
    lbs_idx_t msg_reg;
    logic test_run_reg;
    logic chan_first_reg;
    logic [13:0] incr_reg;

    // APB handshake.
    logic ack_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic access;
    logic wr_en;
    logic mapped;

    // Descriptor path.
    logic [15:0] rand_val;
    logic push_valid;
    logic push_ready;
    logic push;
    lbs_desc_s desc_next;
    lbs_pos_s pos_next;

    // Maps raw random bits onto the increment window, folding the top end down.
    function automatic logic [13:0] pick_incr(input logic [8:0] r);
        logic [8:0] off;
        off = (r >= `LBS_INCR_SPAN) ? r - `LBS_INCR_SPAN : r;
        pick_incr = `LBS_INCR_BASE + {5'h00, off};
    endfunction

    // True for every offset that holds a register.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `LBS_CTRL_OFF) || (a == `LBS_STATUS_OFF) || (a == `LBS_LON_OFF) ||
                    (a == `LBS_LAT_OFF) || (a == `LBS_COGSOG_OFF) || (a == `LBS_TIME_OFF) ||
                    (a == `LBS_SLOT_OFF);
    endfunction

    // Builds the message kind and comm-state of one slot of a burst.
    function automatic lbs_desc_s build_msg(
        input lbs_idx_t bidx,
        input lbs_idx_t midx,
        input logic test,
        input logic first_second,
        input logic [13:0] slot,
        input logic [13:0] utc,
        input logic [13:0] incr
    );
        lbs_desc_s d;
        d = '0;
        d.channel = first_second ^ midx[0];
        d.msg_type = `LBS_MSG_POS;
        d.nav_status = `LBS_NAV_ALERT;
        d.time_out = `LBS_TIMEOUT_TOP - bidx;
        if (test) begin
            d.time_out = 3'h0;
            d.nav_status = `LBS_NAV_UNDEF;
            if (midx == 3'h0 || midx == `LBS_LAST_MSG) begin
                d.msg_type = `LBS_MSG_SAFETY;
                d.nav_status = 4'h0;
                d.text_test = 1'b1;
            end
        end else begin
            case (bidx)
                3'h0, 3'h4: begin
                    // Safety broadcasts every fourth burst, pre-announced by time-out 7 and 3.
                    if (midx == `LBS_SAFETY_POS_A || midx == `LBS_SAFETY_POS_B) begin
                        d.msg_type = `LBS_MSG_SAFETY;
                        d.nav_status = 4'h0;
                        d.time_out = 3'h0;
                    end
                end
                3'h1, 3'h3, 3'h5: begin
                    d.sub_msg = slot;
                end
                3'h2: begin
                    d.sub_msg = 14'h0000;
                end
                3'h6: begin
                    d.sub_msg = utc;
                end
                3'h7: begin
                    d.sub_msg = incr;
                end
                default: begin
                    d.sub_msg = 14'h0000;
                end
            endcase
        end
        build_msg = d;
    endfunction

    // APB is answered one cycle into the access phase, so read data comes from flops.
    assign access = psel && penable;
    assign wr_en = access && ack_reg && pwrite && mapped;
    assign mapped = is_mapped(paddr);
    assign pready = ack_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign test_go = wr_en && (paddr == `LBS_CTRL_OFF) && pwdata[`LBS_CTRL_TEST];

    // Ready strobe, read data and error answer for each transfer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            ack_reg <= access && !ack_reg;
            pslverr_reg <= access && !ack_reg && !mapped;
            prdata_reg <= 32'h00000000;
            if (access && !ack_reg && !pwrite) begin
                case (paddr)
                    `LBS_CTRL_OFF: prdata_reg <= {28'h0000000, fix_valid_reg,
                                                 start_second_reg, 1'b0, active_en_reg};
                    `LBS_STATUS_OFF: prdata_reg <= {2'h0, incr_reg, 9'h000, had_fix_reg,
                                                   2'(state_reg), 1'b0, burst_reg};
                    `LBS_LON_OFF: prdata_reg <= {4'h0, lon_reg};
                    `LBS_LAT_OFF: prdata_reg <= {5'h00, lat_reg};
                    `LBS_COGSOG_OFF: prdata_reg <= {6'h00, sog_reg, 4'h0, cog_reg};
                    `LBS_TIME_OFF: prdata_reg <= {10'h000, sec_reg, 2'h0, utc_reg};
                    `LBS_SLOT_OFF: prdata_reg <= {18'h00000, slot_reg};
                    default: prdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // Control register; the test trigger is a write pulse and is not stored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_en_reg <= 1'b0;
            start_second_reg <= 1'b0;
            fix_valid_reg <= 1'b0;
        end else if (wr_en && paddr == `LBS_CTRL_OFF) begin
            active_en_reg <= pwdata[`LBS_CTRL_ACTIVE];
            start_second_reg <= pwdata[`LBS_CTRL_SECOND];
            fix_valid_reg <= pwdata[`LBS_CTRL_FIX];
        end
    end

    // Navigation data written by software from the satellite receiver.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lon_reg <= `LBS_LON_RST;
            lat_reg <= `LBS_LAT_RST;
            cog_reg <= `LBS_COG_RST;
            sog_reg <= `LBS_SOG_RST;
            utc_reg <= `LBS_SUB_RST;
            sec_reg <= `LBS_SEC_RST;
            slot_reg <= `LBS_SUB_RST;
        end else if (wr_en) begin
            case (paddr)
                `LBS_LON_OFF: lon_reg <= pwdata[27:0];
                `LBS_LAT_OFF: lat_reg <= pwdata[26:0];
                `LBS_COGSOG_OFF: begin
                    cog_reg <= pwdata[11:0];
                    sog_reg <= pwdata[`LBS_SOG_LSB +: 10];
                end
                `LBS_TIME_OFF: begin
                    utc_reg <= pwdata[13:0];
                    sec_reg <= pwdata[`LBS_SEC_LSB +: 6];
                end
                `LBS_SLOT_OFF: slot_reg <= pwdata[13:0];
                default: begin
                end
            endcase
        end
    end

    // Last known position follows the live one only while the fix is valid.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_lon_reg <= `LBS_LON_NA;
            last_lat_reg <= `LBS_LAT_NA;
            last_cog_reg <= `LBS_COG_NA;
            last_sog_reg <= `LBS_SOG_NA;
        end else if (fix_valid_reg) begin
            last_lon_reg <= lon_reg;
            last_lat_reg <= lat_reg;
            last_cog_reg <= cog_reg;
            last_sog_reg <= sog_reg;
        end
    end

    // A fix seen during active mode is remembered until the sequencer returns to idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            had_fix_reg <= 1'b0;
        end else if (state_reg == lbs_idle) begin
            had_fix_reg <= 1'b0;
        end else if (!test_run_reg && fix_valid_reg) begin
            had_fix_reg <= 1'b1;
        end
    end

    // Position fields: live fix, fallback to last known, or the not-available defaults.
    always_comb begin
        pos_next.lon = lon_reg;
        pos_next.lat = lat_reg;
        pos_next.course_over_ground = cog_reg;
        pos_next.speed_over_ground = sog_reg;
        pos_next.tstamp = sec_reg;
        pos_next.sync_state = `LBS_SYNC_UTC;
        if (!fix_valid_reg && had_fix_reg && !test_run_reg) begin
            pos_next.lon = last_lon_reg;
            pos_next.lat = last_lat_reg;
            pos_next.course_over_ground = last_cog_reg;
            pos_next.speed_over_ground = last_sog_reg;
            pos_next.tstamp = `LBS_TS_EST;
            pos_next.sync_state = `LBS_SYNC_EST;
        end else if (!fix_valid_reg) begin
            pos_next.lon = `LBS_LON_NA;
            pos_next.lat = `LBS_LAT_NA;
            pos_next.course_over_ground = `LBS_COG_NA;
            pos_next.speed_over_ground = `LBS_SOG_NA;
            pos_next.tstamp = `LBS_TS_NA;
            pos_next.sync_state = `LBS_SYNC_UTC;
        end
    end

    // Message kind from the sequencer, position block from the selection above.
    always_comb begin
        desc_next = build_msg(burst_reg, msg_reg, test_run_reg, chan_first_reg,
                              slot_reg, utc_reg, incr_reg);
        desc_next.lon = pos_next.lon;
        desc_next.lat = pos_next.lat;
        desc_next.course_over_ground = pos_next.course_over_ground;
        desc_next.speed_over_ground = pos_next.speed_over_ground;
        desc_next.tstamp = pos_next.tstamp;
        desc_next.sync_state = pos_next.sync_state;
    end

    assign push_valid = (state_reg == lbs_send);
    assign push = push_valid && push_ready;

    // Mode sequencer: idle, waiting for the minute tick, or emitting eight messages.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= lbs_idle;
            test_run_reg <= 1'b0;
            chan_first_reg <= 1'b0;
        end else begin
            case (state_reg)
                lbs_idle: begin
                    if (active_en_reg) begin
                        state_reg <= lbs_wait;
                        test_run_reg <= 1'b0;
                        chan_first_reg <= start_second_reg;
                    end else if (test_go) begin
                        state_reg <= lbs_send;
                        test_run_reg <= 1'b1;
                        chan_first_reg <= pwdata[`LBS_CTRL_SECOND];
                    end
                end
                lbs_wait: begin
                    if (!active_en_reg) begin
                        state_reg <= lbs_idle;
                    end else if (burst_start) begin
                        state_reg <= lbs_send;
                    end
                end
                lbs_send: begin
                    if (push && msg_reg == `LBS_LAST_MSG) begin
                        // A test burst runs once; an active burst waits for the next tick.
                        state_reg <= (test_run_reg || !active_en_reg) ? lbs_idle : lbs_wait;
                        test_run_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= lbs_idle;
                end
            endcase
        end
    end

    // Message position within the burst; eight pushes close a burst.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_reg <= 3'h0;
        end else if (state_reg != lbs_send) begin
            msg_reg <= 3'h0;
        end else if (push) begin
            msg_reg <= msg_reg + 3'h1;
        end
    end

    // Burst index, held as burst number minus one, wraps from eight back to one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_reg <= 3'h0;
        end else if (state_reg == lbs_idle) begin
            burst_reg <= 3'h0;
        end else if (push && msg_reg == `LBS_LAST_MSG && !test_run_reg) begin
            burst_reg <= burst_reg + 3'h1;
        end
    end

    // Increment is drawn once as burst eight starts, so all its messages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            incr_reg <= `LBS_INCR_BASE;
        end else if (state_reg == lbs_wait && burst_start && burst_reg == `LBS_LAST_BURST) begin
            incr_reg <= pick_incr(rand_val[8:0]);
        end
    end

    lbs_rand u_rand (
        .pclk(pclk),
        .presetn(presetn),
        .rand_val(rand_val)
    );

    // Four-entry queue toward the radio; a stalled radio holds the sequencer.
    lbs_fifo #(
        .WIDTH($bits(lbs_desc_s)),
        .DEPTH(4)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(desc_next),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_desc)
    );

endmodule
`default_nettype wire

// file: tb/lbs_props.sv
// Assertions on the burst scheduler's radio stream.
// Assumes binding to lbs_top; it sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module lbs_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire lbs_pkg::lbs_desc_s tx_desc
);
    import lbs_pkg::*;
    lbs_desc_s d;
    // Short alias keeps each property on a line or two.
    assign d = tx_desc;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    msg_kind_a: assert property (tx_valid |-> d.msg_type inside {6'h01, 6'h0e})
        else $error("unknown message type");
    safety_zero_a: assert property (tx_valid && d.msg_type == 6'h0e
        |-> d.nav_status == 4'h0 && d.sub_msg == 14'h0) else $error("safety fields set");
    report_nav_a: assert property (tx_valid && d.msg_type == 6'h01
        |-> d.nav_status inside {4'he, 4'hf}) else $error("bad report status");
    test_report_a: assert property (tx_valid && d.nav_status == 4'hf
        |-> d.time_out == 3'h0 && d.sub_msg == 14'h0) else $error("test report fields");
    incr_window_a: assert property (tx_valid && d.nav_status == 4'he && d.time_out == 3'h0
        |-> d.sub_msg inside {[14'd2025:14'd2475]}) else $error("increment out of window");
    stall_hold_a: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_desc)) else $error("descriptor dropped");
    est_stamp_a: assert property (tx_valid && d.tstamp == 6'h3e |-> d.sync_state == 2'h3)
        else $error("estimated stamp without sync 3");
    no_fix_a: assert property (tx_valid && d.tstamp == 6'h3f
        |-> d.lon == 28'h6791ac0 && d.lat == 27'h3412140) else $error("default position");
endmodule
bind lbs_top lbs_props lbs_props_i (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_desc(tx_desc));
`default_nettype wire

// file: tb/lbs_radio.sv
// Radio side model: accepts descriptors and records them in order.
// Assumes the bench drives stall to hold off acceptance.
`timescale 1ns/100ps
`default_nettype none
module lbs_radio (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic tx_valid,
    input wire lbs_pkg::lbs_desc_s tx_desc,
    output logic tx_ready
);
    import lbs_pkg::*;
    lbs_desc_s rx_q[$];
    // Ready drops while the bench stalls the channel pair.
    assign tx_ready = !stall;
    // A descriptor counts as sent at the edge where valid meets ready.
    always @(posedge pclk) begin
        if (presetn && tx_valid && tx_ready) begin
            rx_q.push_back(tx_desc);
        end
    end
endmodule
`default_nettype wire

// file: tb/lbs_top_bench.sv
// Testbench of the burst scheduler: registers, test burst and active cycle.
// Assumes lbs_radio as the far side and lbs_props bound to the design.
`timescale 1ns/100ps
`default_nettype none
module lbs_top_bench;
    import lbs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, burst_start = 0, stall = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, tx_valid, tx_ready, rerr;
    lbs_desc_s tx_desc;
    int fail_count = 0, cmp_count = 0;
    // Free-running 25 MHz clock.
    always #20 pclk = ~pclk;
    lbs_top lbs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .burst_start(burst_start), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_desc(tx_desc));
    lbs_radio lbs_radio_i (.pclk(pclk), .presetn(presetn), .stall(stall),
        .tx_valid(tx_valid), .tx_desc(tx_desc), .tx_ready(tx_ready));
    task complete_run();
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        if (n >= 20) complete_run();
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Optionally pulses the minute tick, then waits for eight descriptors.
    task run_burst(input logic go);
        int n;
        burst_start <= go;
        @(posedge pclk);
        burst_start <= 0;
        for (n = 0; n < 300 && lbs_radio_i.rx_q.size() < 8; n++) @(posedge pclk);
        if (n >= 300) fail_count++;
        if (n >= 300) complete_run();
    endtask
    // Judges a received burst against the sequence table, then empties it.
    task check_burst(input int b, input logic tst, input logic [5:0] ts, input logic sc);
        lbs_desc_s d;
        logic saf;
        for (int m = 0; m < 8; m++) begin
            d = lbs_radio_i.rx_q[m];
            saf = tst ? (m == 0 || m == 7) : ((b == 0 || b == 4) && (m == 4 || m == 5));
            chk("channel", d.channel, sc ^ m[0]);
            chk("type", d.msg_type, saf ? 6'h0e : 6'h01);
            chk("stamp", d.tstamp, ts);
            chk("sync", d.sync_state, (ts == 6'h3e) ? 2'h3 : 2'h0);
            chk("lon", d.lon, (ts == 6'h3f) ? 28'h6791ac0 : 28'h0123456);
            if (saf) chk("text", d.text_test, tst);
            else if (tst) chk("test_nav", d.nav_status, 4'hf);
            else begin
                chk("nav", d.nav_status, 4'he);
                chk("time_out", d.time_out, 7 - b);
                if (b == 7) chk("incr", d.sub_msg inside {[2025:2475]}, 1);
                else if (b == 6) chk("utc", d.sub_msg, 14'h2aa);
                else chk("sub", d.sub_msg, b[0] ? 14'h123 : 14'h0);
            end
        end
        lbs_radio_i.rx_q.delete();
    endtask
    // Reset values, the error answer of an unused offset, then navigation data.
    task scen_regs();
        apb(0, 8'h04, 0);
        chk("status_rst", rdat, 32'h07e90000);
        apb(0, 8'h1c, 0);
        chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
        apb(1, 8'h18, 32'h123);
        apb(1, 8'h14, 32'h001502aa);
        apb(1, 8'h08, 32'h0123456);
    endtask
    // Test burst from the second channel, held by a stalled radio, then released.
    task scen_test();
        stall <= 1;
        apb(1, 8'h00, 32'h6);
        repeat (20) @(posedge pclk);
        chk("held", tx_valid, 1);
        stall <= 0;
        run_burst(0);
        check_burst(0, 1, 6'h3f, 1);
        repeat (20) @(posedge pclk);
        chk("one_burst", lbs_radio_i.rx_q.size(), 0);
    endtask
    // Nine active bursts with a fix that is lost before the third one.
    task scen_active();
        apb(1, 8'h00, 32'h9);
        for (int b = 0; b < 9; b++) begin
            if (b == 2) apb(1, 8'h00, 32'h1);
            run_burst(1);
            check_burst(b % 8, 0, (b < 2) ? 6'h15 : 6'h3e, 0);
        end
    endtask
    // Stop, then restart on the second channel without a fix: burst one, defaults.
    task scen_restart();
        apb(1, 8'h00, 32'h0);
        apb(0, 8'h04, 0);
        chk("stopped", rdat[15:0], 16'h0000);
        apb(1, 8'h00, 32'h5);
        run_burst(1);
        check_burst(0, 0, 6'h3f, 1);
    endtask
    // Main sequence: reset, then each scenario in turn, then the verdict.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        scen_regs();
        scen_test();
        scen_active();
        scen_restart();
        complete_run();
    end
endmodule
`default_nettype wire
